//--- asb_pkg.sv
package asb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int AXES = 3;
  localparam int AXIS_W = 12;
  localparam int TRIM_W = 8;
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int SAMPLE_W = AXES * AXIS_W;
  localparam int EVT_W = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_TRIM_X = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_Y = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_Z = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_STORE_CFG = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_STORE_STATUS = 8'h2A;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'h2B;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 8'h2C;

  // reset values
  localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

  // event status bit positions
  localparam int EVT_OVF = 0;
  localparam int EVT_WMRK = 1;
  localparam int EVT_GATE = 2;
  localparam int EVT_TRIG = 3;

  localparam logic [CNT_W-1:0] DEPTH_CNT = 6'h20;

  typedef enum logic [1:0] {
    ASB_MODE_OFF = 2'b00,
    ASB_MODE_STREAM = 2'b01,
    ASB_MODE_STOP = 2'b10,
    ASB_MODE_TRIG = 2'b11
  } asb_mode_t;

  typedef enum logic [1:0] {
    ASB_PH_ARMED = 2'b00,
    ASB_PH_POST = 2'b01,
    ASB_PH_DONE = 2'b10
  } asb_phase_t;

  // field order is bit 7 down to bit 0
  typedef struct packed {
    logic read_newest_first;
    asb_mode_t mode;
    logic gate;
    logic trigger_on_within_threshold;
    logic trigger_on_outside_threshold;
    logic spare;
    logic trigger_on_orientation;
  } asb_cfg_t;

  typedef struct packed {
    logic [AXES-1:0][AXIS_W-1:0] axis;
  } asb_sample_t;
endpackage

//--- asb_buffer.sv
// Operation
// - each axis trim is an 8-bit two's complement value, -128 to 127
// - trim is applied as trim times two output LSBs
// - X, Y, Z trims sit at 22h, 23h, 24h, each for its own axis
// - read-order bit 0 returns oldest sample first; reset order
// - read-order bit 1 returns newest sample first
// - configuration writes refused while measuring or trigger pin function set
// - collection mode in bits 6:5; code 00 disables the buffer
// - stream mode: full buffer drops oldest entry, keeps latest 32
// - stop mode: full buffer drops every new sample until one is read out
// - trigger mode before trigger runs circular, keeping watermark count
// - after trigger store 32 minus watermark samples, set overflow, stop
// - flush or full readout clears overflow and re-arms trigger
// - trigger sources enabled by bits 3, 2 and 0
// - gate 0 flushes on power transition; gate 1 keeps data, flags drops
// - disable or flush empties buffer, clears overflow, watermark, count
`timescale 1ns/1ps
`default_nettype none
module asb_buffer
  import asb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // device state
  input wire logic measure_active,
  input wire logic second_pin_trigger_function,
  input wire logic [CNT_W-1:0] watermark_level,
  input wire logic flush_req,
  input wire logic power_transition,
  // trigger events
  input wire logic data_change_within,
  input wire logic data_change_outside,
  input wire logic orientation_change,
  // sample input
  input wire logic sample_valid,
  input wire asb_sample_t sample_raw,
  // buffer readout
  input wire logic pop,
  output logic pop_valid,
  output asb_sample_t pop_data,
  // flags
  output logic store_overflow_flag,
  output logic watermark_flag,
  output logic gate_error,
  output logic [CNT_W-1:0] sample_count,
  output logic irq
);

  typedef struct packed {
    logic [AXES-1:0][TRIM_W-1:0] trim;
    asb_cfg_t cfg;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [CNT_W-1:0] cnt;
    asb_phase_t phase;
    logic [CNT_W-1:0] post;
    logic ovf;
    logic gate_closed;
    logic gate_err;
    logic [DATA_W-1:0] rdata;
    logic [SAMPLE_W-1:0] pop_data;
    logic pop_valid;
  } asb_state_t;

  asb_state_t s;
  asb_state_t next_s;
  asb_sample_t corrected;

  // saturating add keeps a near-full-scale reading from wrapping sign
  function automatic logic [AXIS_W-1:0] apply_trim(input logic [AXIS_W-1:0] raw,
                                                   input logic [TRIM_W-1:0] trim);
    logic [AXIS_W:0] sum;
    sum = {raw[AXIS_W-1], raw} + {{(AXIS_W-TRIM_W){trim[TRIM_W-1]}}, trim, 1'b0};
    if (sum[AXIS_W] != sum[AXIS_W-1]) begin
      apply_trim = sum[AXIS_W] ? {1'b1, {(AXIS_W-1){1'b0}}} : {1'b0, {(AXIS_W-1){1'b1}}};
    end else begin
      apply_trim = sum[AXIS_W-1:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : gen_axis
      assign corrected.axis[g] = apply_trim(sample_raw.axis[g], s.trim[g]);
    end
  endgenerate

  logic [CNT_W-1:0] pre_cap;
  logic [CNT_W-1:0] post_limit;
  logic trig_hit;
  logic wmrk_now;

  // watermark above depth behaves as a full-depth history
  assign pre_cap = (watermark_level > DEPTH_CNT) ? DEPTH_CNT : watermark_level;
  assign post_limit = DEPTH_CNT - pre_cap;
  assign trig_hit = (data_change_within & s.cfg.trigger_on_within_threshold) |
                    (data_change_outside & s.cfg.trigger_on_outside_threshold) |
                    (orientation_change & s.cfg.trigger_on_orientation);
  assign wmrk_now = (watermark_level != 6'h00) && (s.cnt >= watermark_level);

  always_comb begin
    logic flush;
    logic readout_all;
    logic write;
    logic dropped;
    logic fired;
    logic cfg_open;
    logic [PTR_W-1:0] idx;
    logic [EVT_W-1:0] set;
    logic [EVT_W-1:0] clr;
    flush = 1'b0;
    readout_all = 1'b0;
    write = 1'b0;
    dropped = 1'b0;
    fired = 1'b0;
    cfg_open = 1'b0;
    idx = 5'h00;
    set = 4'h0;
    clr = 4'h0;
    next_s = s;
    next_s.pop_valid = 1'b0;
    next_s.rdata = 8'h00;

    // register writes
    cfg_open = !measure_active && !second_pin_trigger_function;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_TRIM_X: next_s.trim[0] = reg_wdata;
        ADDR_TRIM_Y: next_s.trim[1] = reg_wdata;
        ADDR_TRIM_Z: next_s.trim[2] = reg_wdata;
        ADDR_STORE_CFG: begin
          if (cfg_open) begin
            next_s.cfg = asb_cfg_t'(reg_wdata);
          end
        end
        ADDR_EVT_STATUS: clr = reg_wdata[EVT_W-1:0];
        ADDR_EVT_MASK: next_s.mask = reg_wdata[EVT_W-1:0];
        default: ;
      endcase
    end

    // register reads, data stand one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_TRIM_X: next_s.rdata = s.trim[0];
        ADDR_TRIM_Y: next_s.rdata = s.trim[1];
        ADDR_TRIM_Z: next_s.rdata = s.trim[2];
        ADDR_STORE_CFG: next_s.rdata = s.cfg;
        ADDR_STORE_STATUS: next_s.rdata = {s.ovf, wmrk_now, s.cnt};
        ADDR_EVT_STATUS: next_s.rdata = {4'h0, s.evt};
        ADDR_EVT_MASK: next_s.rdata = {4'h0, s.mask};
        default: next_s.rdata = 8'h00;
      endcase
    end

    flush = flush_req || (s.cfg.mode == ASB_MODE_OFF) ||
            (power_transition && !s.cfg.gate);

    // readout; a pop in the same cycle as a sample is served first
    if (pop && s.cnt != 6'h00 && !flush) begin
      if (s.cfg.read_newest_first) begin
        idx = s.wp - 5'h01;
        next_s.wp = idx;
      end else begin
        idx = s.wp - s.cnt[PTR_W-1:0];
      end
      next_s.pop_data = s.mem[idx];
      next_s.pop_valid = 1'b1;
      next_s.cnt = s.cnt - 6'h01;
      readout_all = (next_s.cnt == 6'h00);
    end

    if (flush || readout_all) begin
      next_s.ovf = 1'b0;
      next_s.phase = ASB_PH_ARMED;
      next_s.post = 6'h00;
      next_s.gate_closed = 1'b0;
      next_s.gate_err = 1'b0;
    end
    if (flush) begin
      next_s.cnt = 6'h00;
      next_s.wp = 5'h00;
    end

    // a gated transition only holds back data that is actually stored
    if (power_transition && s.cfg.gate && !flush && next_s.cnt != 6'h00) begin
      next_s.gate_closed = 1'b1;
    end

    if (!flush && s.cfg.mode == ASB_MODE_TRIG && next_s.phase == ASB_PH_ARMED && trig_hit) begin
      fired = 1'b1;
      next_s.phase = (post_limit == 6'h00) ? ASB_PH_DONE : ASB_PH_POST;
      next_s.post = 6'h00;
      if (post_limit == 6'h00) begin
        next_s.ovf = 1'b1;
      end
    end

    if (sample_valid && !flush) begin
      if (next_s.gate_closed) begin
        dropped = 1'b1;
        next_s.gate_err = 1'b1;
      end else begin
        unique case (s.cfg.mode)
          ASB_MODE_STREAM: begin
            write = 1'b1;
            if (next_s.cnt == DEPTH_CNT) begin
              next_s.ovf = 1'b1;
            end else begin
              next_s.cnt = next_s.cnt + 6'h01;
            end
          end
          ASB_MODE_STOP: begin
            if (next_s.cnt == DEPTH_CNT) begin
              next_s.ovf = 1'b1;
            end else begin
              write = 1'b1;
              next_s.cnt = next_s.cnt + 6'h01;
            end
          end
          ASB_MODE_TRIG: begin
            unique case (next_s.phase)
              ASB_PH_ARMED: begin
                write = 1'b1;
                if (next_s.cnt < pre_cap) begin
                  next_s.cnt = next_s.cnt + 6'h01;
                end
              end
              ASB_PH_POST: begin
                write = 1'b1;
                if (next_s.cnt != DEPTH_CNT) begin
                  next_s.cnt = next_s.cnt + 6'h01;
                end
                next_s.post = next_s.post + 6'h01;
                if (next_s.post >= post_limit) begin
                  next_s.phase = ASB_PH_DONE;
                  next_s.ovf = 1'b1;
                end
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end
    end

    if (write) begin
      next_s.mem[next_s.wp] = corrected;
      next_s.wp = next_s.wp + 5'h01;
    end

    // set wins over a clear in the same cycle
    set[EVT_OVF] = next_s.ovf && !s.ovf;
    set[EVT_WMRK] = (watermark_level != 6'h00) && (next_s.cnt >= watermark_level) && !wmrk_now;
    set[EVT_GATE] = dropped;
    set[EVT_TRIG] = fired;
    next_s.evt = (s.evt & ~clr) | set;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.trim <= {AXES{TRIM_RESET}};
      s.cfg <= asb_cfg_t'(CFG_RESET);
      s.evt <= EVT_RESET;
      s.mask <= MASK_RESET;
      s.phase <= ASB_PH_ARMED;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign pop_valid = s.pop_valid;
  assign pop_data = asb_sample_t'(s.pop_data);
  assign store_overflow_flag = s.ovf;
  assign watermark_flag = wmrk_now;
  assign gate_error = s.gate_err;
  assign sample_count = s.cnt;
  assign irq = |(s.evt & s.mask);

  AST_TRIM_HELD: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_TRIM_Y) |=> (s.trim[1] == $past(reg_wdata)) && $stable(s.trim[0]))
    else $error("y trim not taken from write");

  AST_TRIM_SCALE: assert property (@(posedge clock) disable iff (rst)
    (sample_raw.axis[0][11:10] == 2'b00) |->
      ($signed(corrected.axis[0]) == $signed(sample_raw.axis[0]) + 2 * $signed(s.trim[0])))
    else $error("x offset not twice the trim");

  AST_FIFO_OLDEST: assert property (@(posedge clock) disable iff (rst)
    (pop && s.cnt != 6'h00 && !s.cfg.read_newest_first && !flush_req && s.cfg.mode != ASB_MODE_OFF &&
     !power_transition) |=> pop_valid && (s.pop_data == $past(s.mem[s.wp - s.cnt[PTR_W-1:0]])))
    else $error("fifo read did not return oldest");

  AST_LIFO_NEWEST: assert property (@(posedge clock) disable iff (rst)
    (pop && s.cnt != 6'h00 && s.cfg.read_newest_first && !flush_req && s.cfg.mode != ASB_MODE_OFF &&
     !power_transition) |=> pop_valid && (s.pop_data == $past(s.mem[s.wp - 5'h01])))
    else $error("lifo read did not return newest");

  AST_CFG_LOCKED: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_STORE_CFG && (measure_active || second_pin_trigger_function))
      |=> $stable(s.cfg))
    else $error("config changed while locked");

  AST_OFF_EMPTY: assert property (@(posedge clock) disable iff (rst)
    (s.cfg.mode == ASB_MODE_OFF || flush_req) |=> (s.cnt == 6'h00) && !s.ovf && !watermark_flag)
    else $error("disabled or flushed buffer not empty");

  AST_STREAM_KEEP: assert property (@(posedge clock) disable iff (rst)
    (s.cfg.mode == ASB_MODE_STREAM && s.cnt == DEPTH_CNT && sample_valid && !pop && !flush_req &&
     !power_transition && !s.gate_closed) |=> (s.cnt == DEPTH_CNT) && s.ovf && (s.wp == $past(s.wp) + 5'h01))
    else $error("stream mode did not replace oldest");

  AST_STOP_DROP: assert property (@(posedge clock) disable iff (rst)
    (s.cfg.mode == ASB_MODE_STOP && s.cnt == DEPTH_CNT && !pop && !flush_req && !power_transition)
      |=> $stable(s.wp) && $stable(s.mem) && (s.cnt == DEPTH_CNT))
    else $error("stop mode stored into full buffer");

  // a trigger beside a sample makes that sample post-trigger, so it is left out here
  AST_PRE_HISTORY: assert property (@(posedge clock) disable iff (rst)
    (s.cfg.mode == ASB_MODE_TRIG && s.phase == ASB_PH_ARMED && s.cnt <= pre_cap && !trig_hit)
      |=> (s.cnt <= $past(pre_cap)))
    else $error("pre-trigger history beyond watermark");

  AST_POST_STOP: assert property (@(posedge clock) disable iff (rst)
    (s.phase == ASB_PH_DONE) |-> s.ovf && (s.post <= post_limit))
    else $error("trigger collection stopped without overflow");

  AST_REARM: assert property (@(posedge clock) disable iff (rst)
    (pop && s.cnt == 6'h01 && s.cfg.mode == ASB_MODE_TRIG && !trig_hit)
      |=> !s.ovf && (s.phase == ASB_PH_ARMED))
    else $error("readout did not re-arm trigger");

  AST_GATE_DROP: assert property (@(posedge clock) disable iff (rst)
    (s.gate_closed && sample_valid && !flush_req && s.cfg.mode != ASB_MODE_OFF && !pop && !power_transition)
      |=> s.gate_err && $stable(s.wp) && s.evt[EVT_GATE])
    else $error("gated sample not flagged");

  AST_TRIG_SOURCE: assert property (@(posedge clock) disable iff (rst)
    (s.cfg.mode == ASB_MODE_TRIG && s.phase == ASB_PH_ARMED && data_change_outside &&
     s.cfg.trigger_on_outside_threshold && !flush_req && !power_transition)
      |=> (s.phase != ASB_PH_ARMED) && s.evt[EVT_TRIG])
    else $error("enabled outside-threshold event did not trigger");

  AST_TRIG_IDLE: assert property (@(posedge clock) disable iff (rst)
    (s.phase == ASB_PH_ARMED && !s.cfg.trigger_on_within_threshold && !s.cfg.trigger_on_outside_threshold &&
     !s.cfg.trigger_on_orientation) |=> (s.phase == ASB_PH_ARMED))
    else $error("trigger fired with every source disabled");

  // a closed gate must keep exactly what it held
  AST_GATE_CLOSE: assert property (@(posedge clock) disable iff (rst)
    (power_transition && s.cfg.gate && s.cfg.mode != ASB_MODE_OFF && !flush_req && !pop && s.cnt != 6'h00)
      |=> s.gate_closed && (s.cnt == $past(s.cnt)))
    else $error("gated transition did not hold the buffer");

  AST_GATE_FLUSH: assert property (@(posedge clock) disable iff (rst)
    (power_transition && !s.cfg.gate) |=> (s.cnt == 6'h00) && !s.ovf && !s.gate_err)
    else $error("ungated transition did not flush");

  AST_READOUT_OPEN: assert property (@(posedge clock) disable iff (rst)
    (pop && s.cnt == 6'h01)
      |=> !s.gate_err && !s.gate_closed)
    else $error("full readout left the gate closed");

endmodule
`default_nettype wire

//--- asb_host.sv
`timescale 1ns/1ps
`default_nettype none
module asb_host
  import asb_pkg::*;
(
  // clock
  input wire logic clock,
  // register port
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // device state and readout
  output logic measure_active,
  output logic second_pin_trigger_function,
  output logic flush_req,
  output logic pop
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    measure_active = 1'b0;
    second_pin_trigger_function = 1'b0;
    flush_req = 1'b0;
    pop = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // setup writes only land while measuring is stopped
  task automatic cfg(input logic [DATA_W-1:0] d);
    @(posedge clock);
    measure_active <= 1'b0;
    second_pin_trigger_function <= 1'b0;
    wr(ADDR_STORE_CFG, d);
    measure_active <= 1'b1;
  endtask

  // hold the setup lock bits at a chosen level
  task automatic lock(input logic m, input logic p);
    @(posedge clock);
    measure_active <= m;
    second_pin_trigger_function <= p;
  endtask

  task automatic pop_one();
    @(posedge clock);
    pop <= 1'b1;
    @(posedge clock);
    pop <= 1'b0;
  endtask

  // flushing re-arms a finished trigger capture
  task automatic flush();
    @(posedge clock);
    flush_req <= 1'b1;
    @(posedge clock);
    flush_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb_accel_offset_and_sample_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_accel_offset_and_sample_buffer
  import asb_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr, reg_rd, measure_active, second_pin_trigger_function, flush_req, pop;
  logic [DATA_W-1:0] reg_rdata;
  logic [CNT_W-1:0] watermark_level, sample_count;
  logic power_transition, data_change_within, data_change_outside, orientation_change;
  logic sample_valid, pop_valid, store_overflow_flag, watermark_flag, gate_error, irq;
  asb_sample_t sample_raw, pop_data;
  int err_count = 0;
  int comparisons = 0;

  always #50 clock = ~clock;

  asb_host u_asb_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .measure_active(measure_active),
    .second_pin_trigger_function(second_pin_trigger_function), .flush_req(flush_req), .pop(pop));

  asb_buffer u_asb_buffer (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .measure_active(measure_active),
    .second_pin_trigger_function(second_pin_trigger_function), .watermark_level(watermark_level),
    .flush_req(flush_req), .power_transition(power_transition), .data_change_within(data_change_within),
    .data_change_outside(data_change_outside), .orientation_change(orientation_change),
    .sample_valid(sample_valid), .sample_raw(sample_raw), .pop(pop), .pop_valid(pop_valid),
    .pop_data(pop_data), .store_overflow_flag(store_overflow_flag), .watermark_flag(watermark_flag),
    .gate_error(gate_error), .sample_count(sample_count), .irq(irq));

  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  function automatic asb_sample_t smp(input int i);
    logic [AXIS_W-1:0] v;
    v = AXIS_W'(i);
    return {v, v, v};
  endfunction

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    u_asb_host.rd(a, d);
    chk("reg_rdata", 36'(exp), 36'(d));
  endtask

  task automatic push(input int i);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_raw <= smp(i);
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask

  task automatic pop_chk(input asb_sample_t exp);
    u_asb_host.pop_one();
    #1;
    chk("pop_valid", 36'h1, 36'(pop_valid));
    chk("pop_data", exp, pop_data);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one-cycle event: 0 power, 1 within, 2 outside, other orientation
  task automatic pulse(input int which);
    @(posedge clock);
    case (which)
      0: power_transition <= 1'b1;
      1: data_change_within <= 1'b1;
      2: data_change_outside <= 1'b1;
      default: orientation_change <= 1'b1;
    endcase
    @(posedge clock);
    power_transition <= 1'b0;
    data_change_within <= 1'b0;
    data_change_outside <= 1'b0;
    orientation_change <= 1'b0;
  endtask

  task automatic t_regs();
    rd_chk(ADDR_TRIM_X, TRIM_RESET);
    rd_chk(ADDR_TRIM_Y, TRIM_RESET);
    rd_chk(ADDR_TRIM_Z, TRIM_RESET);
    rd_chk(ADDR_STORE_CFG, CFG_RESET);
    rd_chk(8'h30, 8'h00);
    u_asb_host.wr(ADDR_TRIM_X, 8'h7F);
    u_asb_host.wr(ADDR_TRIM_Y, 8'h80);
    u_asb_host.wr(ADDR_TRIM_Z, 8'h10);
    rd_chk(ADDR_TRIM_X, 8'h7F);
    rd_chk(ADDR_TRIM_Y, 8'h80);
    rd_chk(ADDR_TRIM_Z, 8'h10);
    $display("regs done");
  endtask

  // extreme trims: +127 and -128 on different axes
  task automatic t_trim();
    u_asb_host.cfg(8'h20);
    push(1);
    pop_chk({12'h021, 12'hF01, 12'h0FF});
    u_asb_host.wr(ADDR_TRIM_X, 8'h00);
    u_asb_host.wr(ADDR_TRIM_Y, 8'h00);
    u_asb_host.wr(ADDR_TRIM_Z, 8'h00);
    u_asb_host.cfg(8'h00);
    $display("trim done");
  endtask

  task automatic t_order();
    u_asb_host.cfg(8'h20);
    push(1);
    push(2);
    push(3);
    pop_chk(smp(1));
    u_asb_host.cfg(8'hA0);
    pop_chk(smp(3));
    u_asb_host.wr(ADDR_STORE_CFG, 8'h00);
    rd_chk(ADDR_STORE_CFG, 8'hA0);
    u_asb_host.cfg(8'h00);
    idle(2);
    chk("sample_count", 36'h0, 36'(sample_count));
    $display("order done");
  endtask

  task automatic t_stream();
    u_asb_host.cfg(8'h20);
    for (int i = 0; i < 33; i++) push(i);
    idle(3);
    chk("sample_count", 36'd32, 36'(sample_count));
    pop_chk(smp(1));
    u_asb_host.cfg(8'h00);
    $display("stream done");
  endtask

  task automatic t_stop();
    u_asb_host.wr(ADDR_EVT_MASK, 8'h01);
    u_asb_host.cfg(8'h40);
    for (int i = 0; i < 33; i++) push(i);
    idle(3);
    chk("sample_count", 36'd32, 36'(sample_count));
    chk("irq", 36'h1, 36'(irq));
    u_asb_host.wr(ADDR_EVT_STATUS, 8'h01);
    idle(1);
    chk("irq", 36'h0, 36'(irq));
    for (int i = 0; i < 32; i++) pop_chk(smp(i));
    idle(2);
    chk("store_overflow_flag", 36'h0, 36'(store_overflow_flag));
    u_asb_host.cfg(8'h00);
    $display("stop done");
  endtask

  task automatic t_trig();
    @(posedge clock);
    watermark_level <= 6'h04;
    u_asb_host.cfg(8'h61);
    for (int i = 0; i < 10; i++) push(i);
    @(posedge clock);
    data_change_within <= 1'b1;
    @(posedge clock);
    data_change_within <= 1'b0;
    for (int i = 10; i < 14; i++) push(i);
    idle(3);
    chk("sample_count", 36'd4, 36'(sample_count));
    chk("watermark_flag", 36'h1, 36'(watermark_flag));
    @(posedge clock);
    orientation_change <= 1'b1;
    @(posedge clock);
    orientation_change <= 1'b0;
    for (int i = 14; i < 54; i++) push(i);
    idle(3);
    chk("sample_count", 36'd32, 36'(sample_count));
    chk("store_overflow_flag", 36'h1, 36'(store_overflow_flag));
    pop_chk(smp(10));
    u_asb_host.flush();
    idle(2);
    chk("sample_count", 36'h0, 36'(sample_count));
    chk("store_overflow_flag", 36'h0, 36'(store_overflow_flag));
    chk("watermark_flag", 36'h0, 36'(watermark_flag));
    chk("gate_error", 36'h0, 36'(gate_error));
    $display("trigger done");
  endtask

  // gate closed by a power transition, reopened by a full readout
  task automatic t_gate();
    u_asb_host.wr(ADDR_EVT_STATUS, 8'h0F);
    u_asb_host.cfg(8'h30);
    push(1);
    push(2);
    pulse(0);
    push(3);
    idle(2);
    chk("gate_error", 36'h1, 36'(gate_error));
    chk("sample_count", 36'd2, 36'(sample_count));
    rd_chk(ADDR_STORE_STATUS, 8'h02);
    rd_chk(ADDR_EVT_STATUS, 8'h04);
    pop_chk(smp(1));
    pop_chk(smp(2));
    push(4);
    idle(2);
    chk("gate_error", 36'h0, 36'(gate_error));
    chk("sample_count", 36'd1, 36'(sample_count));
    u_asb_host.cfg(8'h20);
    pulse(0);
    idle(2);
    chk("sample_count", 36'h0, 36'(sample_count));
    u_asb_host.lock(1'b0, 1'b1);
    u_asb_host.wr(ADDR_STORE_CFG, 8'h00);
    rd_chk(ADDR_STORE_CFG, 8'h20);
    u_asb_host.cfg(8'h00);
    $display("gate done");
  endtask

  // outside and within sources, re-armed by a full readout
  task automatic t_trig_src();
    @(posedge clock);
    watermark_level <= 6'h1F;
    u_asb_host.wr(ADDR_EVT_STATUS, 8'h0F);
    u_asb_host.cfg(8'h6C);
    for (int i = 0; i < 3; i++) push(i);
    pulse(2);
    push(3);
    push(4);
    idle(2);
    chk("sample_count", 36'd4, 36'(sample_count));
    chk("store_overflow_flag", 36'h1, 36'(store_overflow_flag));
    rd_chk(ADDR_EVT_STATUS, 8'h09);
    rd_chk(ADDR_EVT_MASK, 8'h01);
    chk("irq", 36'h1, 36'(irq));
    for (int i = 0; i < 4; i++) pop_chk(smp(i));
    idle(1);
    chk("store_overflow_flag", 36'h0, 36'(store_overflow_flag));
    push(5);
    pulse(1);
    push(6);
    push(7);
    idle(2);
    chk("sample_count", 36'd2, 36'(sample_count));
    chk("store_overflow_flag", 36'h1, 36'(store_overflow_flag));
    u_asb_host.cfg(8'h00);
    $display("trigger sources done");
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    watermark_level = '0;
    power_transition = 1'b0;
    data_change_within = 1'b0;
    data_change_outside = 1'b0;
    orientation_change = 1'b0;
    sample_valid = 1'b0;
    sample_raw = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_trim();
    t_order();
    t_stream();
    t_stop();
    t_trig();
    t_gate();
    t_trig_src();
    results();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
